/* logic/oac_pkg.sv */
package oac_pkg;

  // clock rate and sound speed
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned SOUND_MPS      = 344;

  // trigger pulse width, at least one cycle, rounded down
  localparam int unsigned TRIG_US        = 10;
  localparam int unsigned TRIG_CYC       =
    (TRIG_US * (CLK_HZ / 1_000_000) + 0) > 0 ?
    (TRIG_US * (CLK_HZ / 1_000_000)) : 1;

  // repetition period, long enough for the longest echo
  localparam int unsigned PERIOD_MS      = 60;
  localparam int unsigned PERIOD_CYC     = PERIOD_MS * (CLK_HZ / 1000);

  // echo counter width
  localparam int unsigned ECHO_W         = 20;
  localparam int unsigned DIST_W         = 16;

  // distance in tenths of a micrometre per echo cycle: 344 m/s * 100 ns / 2 = 17.2 um
  localparam int unsigned UM_X10_PER_CYC =
    SOUND_MPS * 1_000_000 / (CLK_HZ / 10) / 2;

  typedef enum logic [2:0] {
    OAC_IDLE = 3'b001,
    OAC_TRIG = 3'b010,
    OAC_WAIT = 3'b100
  } oac_state_t;

  typedef struct packed {
    logic left_en;
    logic right_en;
  } oac_motor_t;

  // one motor channel into the h-bridge: two direction inputs
  typedef struct packed {
    logic in_a;
    logic in_b;
  } oac_hbridge_t;

endpackage

/* logic/oac_top.sv */
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] trigger output high for 10 us per measurement, then low
// [RULE_02] sensor sends an eight-cycle burst after each trigger
// [RULE_03] sensor burst is at 40 kHz
// [RULE_04] echo pulse grows longer with obstacle distance
// [RULE_05] one-way time is half the measured echo time
// [RULE_06] distance equals half of 344 m/s times reflection time
// [RULE_07] side ir outputs are low while an obstacle is seen
// [RULE_08] all four motors enabled together right after startup
// [RULE_09] triggers repeat at a fixed interval while running
// [RULE_10] side inputs only steer when a front obstacle is present
// [RULE_11] right obstacle stops left wheels; left obstacle stops right wheels
// [RULE_12] no front obstacle keeps all motors forward, cycle repeats
// [RULE_13] echo high means front obstacle present
// [RULE_14] h-bridge inputs high-low or low-high turn, equal stops
// [RULE_15] pulse width and interval come from clocked counters
// [RULE_16] both sides blocked with front obstacle: stop left, turn left
module oac_top
  import oac_pkg::*;
#(
  parameter int unsigned PERIOD = oac_pkg::PERIOD_CYC
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   clk_en,
  // ranging sensor
  output logic                        trig,
  input  wire logic                   echo,
  // side ir sensors, active low
  input  wire logic                   ir_left_n,
  input  wire logic                   ir_right_n,
  // h-bridge direction inputs
  output oac_pkg::oac_hbridge_t       motor_left,
  output oac_pkg::oac_hbridge_t       motor_right,
  // measurement result
  output logic [oac_pkg::DIST_W-1:0]  dist_mm,
  output logic                        dist_valid
);
  import oac_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // trigger sequencing

  oac_state_t  state_reg, state_next;
  logic [31:0] tick_reg,  tick_next;

  // last tick of one repetition period
  function automatic logic period_end(input logic [31:0] t);
    period_end = (t >= 32'(PERIOD - 1));
  endfunction

  always_comb begin
    state_next = state_reg;
    tick_next  = tick_reg + 32'h0000_0001; // [RULE_15]
    if (period_end(tick_reg)) begin
      tick_next = '0;
    end
    case (state_reg)
      OAC_IDLE: begin
        if (period_end(tick_reg)) begin
          state_next = OAC_TRIG; // [RULE_09]
        end
      end
      OAC_TRIG: begin
        // pulse width counted on the same tick as the period
        if (tick_reg >= 32'(TRIG_CYC - 1)) begin
          state_next = OAC_WAIT; // [RULE_01]
        end
      end
      OAC_WAIT: begin
        // period end restarts even with no echo fall
        if (period_end(tick_reg)) begin
          state_next = OAC_TRIG; // [RULE_09] [RULE_12]
        end
      end
      default: begin
        state_next = OAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      // first trigger right at release
      state_reg <= OAC_TRIG;
      tick_reg  <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
      tick_reg  <= tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // echo measurement

  logic [ECHO_W-1:0] ecnt_reg,  ecnt_next;
  logic              echo_reg,  echo_next;
  logic [DIST_W-1:0] dist_reg,  dist_next;
  logic              valid_reg, valid_next;

  // echo cycles to mm; the halving is folded into the constant
  function automatic logic [DIST_W-1:0] to_mm(input logic [ECHO_W-1:0] c);
    logic [39:0] p;
    p     = 40'(c) * 40'(UM_X10_PER_CYC); // [RULE_06]
    to_mm = DIST_W'(p / 40'h00_0000_2710); // [RULE_05]
  endfunction

  always_comb begin
    ecnt_next  = ecnt_reg;
    echo_next  = echo;
    dist_next  = dist_reg;
    valid_next = 1'b0;
    case (state_reg)
      OAC_TRIG: begin
        ecnt_next = '0;
      end
      OAC_WAIT: begin
        // longer echo, longer count; saturates, never wraps [RULE_04]
        if (echo && (ecnt_reg != '1)) begin
          ecnt_next = ecnt_reg + ECHO_W'(1);
        end
        // falling echo closes the measurement
        if (echo_reg && !echo) begin
          dist_next  = to_mm(ecnt_reg);
          valid_next = 1'b1;
        end
      end
      default: begin
        ecnt_next = ecnt_reg;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ecnt_reg  <= '0;
      echo_reg  <= 1'b0;
      dist_reg  <= '0;
      valid_reg <= 1'b0;
    end else if (clk_en) begin
      ecnt_reg  <= ecnt_next;
      echo_reg  <= echo_next;
      dist_reg  <= dist_next;
      valid_reg <= valid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // steering

  oac_motor_t mot_reg, mot_next;

  // raw echo steers, so a turn follows the obstacle, not the sequencer
  always_comb begin
    mot_next = '{left_en: 1'b1, right_en: 1'b1}; // [RULE_12]
    if (echo) begin // [RULE_13]
      // side inputs only matter with a front obstacle [RULE_10]
      if (!ir_right_n) begin // [RULE_07]
        // right side wins when both are blocked [RULE_16]
        mot_next.left_en = 1'b0; // [RULE_11]
      end else if (!ir_left_n) begin
        mot_next.right_en = 1'b0; // [RULE_11]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      mot_reg <= '{left_en: 1'b1, right_en: 1'b1}; // [RULE_08]
    end else if (clk_en) begin
      mot_reg <= mot_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // enabled motor: high-low forward, disabled: low-low stop [RULE_14]
  // reverse is never used, so in_b stays low
  function automatic oac_hbridge_t drive_hb(input logic en);
    drive_hb = '{in_a: en, in_b: 1'b0};
  endfunction

  logic [1:0]   en_vec;
  oac_hbridge_t hb_vec [2];

  assign en_vec = {mot_reg.left_en, mot_reg.right_en};

  // index 0 is the right channel, 1 the left
  generate
    for (genvar g = 0; g < 2; g++) begin : g_chan
      assign hb_vec[g] = drive_hb(en_vec[g]);
    end
  endgenerate

  assign trig        = (state_reg == OAC_TRIG);
  assign motor_left  = hb_vec[1];
  assign motor_right = hb_vec[0];
  assign dist_mm     = dist_reg;
  assign dist_valid  = valid_reg;

endmodule // oac_top

/* verif/oac_sva.sv */
`timescale 1ns/1ps
module oac_sva #(parameter int unsigned PERIOD = 300) (
  input logic clock, nrst, clk_en, trig, echo, ir_left_n, ir_right_n,
  input logic dist_valid,
  input oac_pkg::oac_hbridge_t motor_left, motor_right,
  input logic [oac_pkg::DIST_W-1:0] dist_mm);
  int unsigned ec_reg;
  wire [3:0] mot = {motor_left, motor_right};
  always_ff @(posedge clock)
    if (!nrst || clk_en) ec_reg <= !nrst || trig ? 0 : ec_reg + echo;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst || !clk_en);
  trig_width_a: assert property (
    $rose(trig) |-> ##100 $fell(trig)) else $error("width");
  trig_period_a: assert property (
    $rose(trig) |-> ##PERIOD $rose(trig)) else $error("period");
  left_turn_a: assert property (
    echo && !ir_right_n |=> mot == 4'h2) else $error("left");
  right_turn_a: assert property (
    echo && ir_right_n && !ir_left_n |=> mot == 4'h8) else $error("right");
  go_fwd_a: assert property (
    !echo || ir_left_n && ir_right_n |=> mot == 4'ha) else $error("fwd");
  start_fwd_a: assert property (
    $rose(nrst) |-> mot == 4'ha) else $error("start");
  dist_ready_a: assert property (
    $fell(echo) && !trig |=> dist_valid) else $error("valid");
  dist_value_a: assert property (
    dist_valid |-> dist_mm == 16'(ec_reg * 172 / 10_000)) else $error("mm");
  cover property (mot == 4'h2);
  cover property (mot == 4'h8);
  cover property (dist_valid);
endmodule // oac_sva
bind oac_top oac_sva #(.PERIOD(PERIOD)) u_oac_sva (.*);

/* verif/oac_ranger_model.sv */
`timescale 1ns/1ps
module oac_ranger_model (input logic clock, trig, input int len,
  output logic echo);
  int cnt = 0;
  logic trig_q = 0;
  // flight time and burst folded into the echo start
  always @(posedge clock) trig_q <= trig;
  always @(posedge clock) cnt <= trig_q && !trig ? len : cnt - (cnt > 0);
  assign echo = cnt > 0;
endmodule // oac_ranger_model

/* verif/oac_top_test.sv */
`timescale 1ns/1ps
module oac_top_test;
  logic clock = 0, nrst = 0, clk_en = 1, ir_left_n = 1, ir_right_n = 1;
  logic trig, echo, dist_valid;
  logic [15:0] dist_mm;
  oac_pkg::oac_hbridge_t motor_left, motor_right;
  int len = 180, n_mismatch = 0, n_tests = 0;
  logic [5:0] tbl [4] = '{6'h3a, 6'h22, 6'h18, 6'h02};
  always #50 clock = ~clock;
  oac_top #(.PERIOD(300)) u_oac_top (.*);
  oac_ranger_model u_oac_ranger_model (.*);
  task chk(logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h", $time, got);
    end
  endtask
  task give_verdict;
    $display("%0d errors of %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task t_dist;
    while (dist_valid !== 1'b1) @(negedge clock);
    chk(dist_mm, 16'(len * 172 / 10_000));
  endtask
  task t_steer(logic [5:0] row);
    {ir_left_n, ir_right_n} = row[5:4];
    while (echo !== 1'b1) @(negedge clock);
    @(negedge clock);
    chk(16'({motor_left, motor_right}), 16'(row[3:0]));
  endtask
  task t_hold;
    clk_en = 1'b0;
    {ir_left_n, ir_right_n} = 2'b11;
    repeat (3) @(negedge clock);
    chk(16'({motor_left, motor_right}), 16'h0002);
    clk_en = 1'b1;
    @(negedge clock);
    chk(16'({motor_left, motor_right}), 16'h000a);
  endtask
  initial begin
    repeat (9000) @(posedge clock);
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (5) @(negedge clock);
    nrst = 1;
    chk(16'({trig, motor_left, motor_right}), 16'h001a);
    t_dist;
    foreach (tbl[i]) t_steer(tbl[i]);
    t_hold;
    give_verdict;
  end
endmodule // oac_top_test
